// >>> masb_pkg.sv
/*
  Package for the address map and peripheral register bank: region bounds, register table,
  reset values, option-dependent reset values, write masks and the region decoder.
  Assumes a 20-bit byte-addressed CPU space; every register is one byte wide.
*/
package masb_pkg;

  // ==========================================================================
  // Widths
  localparam int BUS_ADDR_W = 20;
  localparam int RDATA_W    = 32;
  localparam int BYTE_W     = 8;
  localparam int BE_W       = 4;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Region bounds
  localparam logic [19:0] SFR0_LO  = 20'h00000;
  localparam logic [19:0] SFR0_HI  = 20'h002FF;
  localparam logic [19:0] RAM_LO   = 20'h00400;
  localparam logic [19:0] RAM_HI   = 20'h00DFF;
  localparam logic [19:0] SFR1_LO  = 20'h02C00;
  localparam logic [19:0] SFR1_HI  = 20'h02FFF;
  localparam logic [19:0] FLASH_LO = 20'h03000;
  localparam logic [19:0] FLASH_HI = 20'h03FFF;
  localparam logic [19:0] ROM_LO   = 20'h08000;
  localparam logic [19:0] ROM_HI   = 20'h0FFFF;
  localparam logic [19:0] VEC_LO   = 20'h0FFDC;
  localparam logic [19:0] VEC_HI   = 20'h0FFFF;

  // Transfer-controller vector area followed by 8-byte control-data blocks 0 to 5
  localparam logic [19:0] XFER_LO    = 20'h02C00;
  localparam logic [19:0] XFER_HI    = 20'h02C6F;
  localparam int          XFER_BYTES = 112;
  localparam int          XFER_IDX_W = 7;

  // ==========================================================================
  // Specially handled registers
  localparam logic [19:0] RSTCAUSE_OFS  = 20'h0000B;
  localparam logic [19:0] WDOG_RFSH_OFS = 20'h0000D;
  localparam logic [19:0] WDOG_STRT_OFS = 20'h0000E;
  localparam int          COLD_WARM_BIT   = 7;
  localparam int          TWOWIRE_SEL_BIT = 0;

  // ==========================================================================
  // Region codes
  typedef enum logic [2:0] {
    REGION_SFR_LOW, REGION_SFR_HIGH, REGION_RAM, REGION_FLASH, REGION_ROM, REGION_VECTOR, REGION_NONE
  } masb_region_t;

  // Reset-value or 004Fh address-steering selection per register
  localparam logic [2:0] OPT_NONE    = 3'h0;
  localparam logic [2:0] OPT_PROTECT = 3'h1;
  localparam logic [2:0] OPT_VDETECT = 3'h2;
  localparam logic [2:0] OPT_SYNSER  = 3'h3;
  localparam logic [2:0] OPT_TWOWIRE = 3'h4;

  // ==========================================================================
  // Register table
  localparam int REG_N       = 48;
  localparam int IDX_CSRC_PROT = 10;
  localparam int IDX_VDET2     = 23;
  localparam int IDX_VMON0     = 25;
  localparam int IDX_TMRC_IRQ  = 29;
  localparam int IDX_SSER_IRQ  = 35;
  localparam int IDX_TWI_IRQ   = 36;
  localparam int IDX_PIN0_IRQ  = 43;
  localparam int IDX_SER_SEL   = 47;

  localparam logic [19:0] REG_OFS [REG_N] = '{
    20'h00004, 20'h00005, 20'h00006, 20'h00007, 20'h00008, 20'h00009, 20'h0000A, 20'h0000C,
    20'h0000F, 20'h00015, 20'h0001C, 20'h00023, 20'h00024, 20'h00025, 20'h00026, 20'h00028,
    20'h00029, 20'h0002A, 20'h0002B, 20'h0002F, 20'h00030, 20'h00031, 20'h00033, 20'h00034,
    20'h00036, 20'h00038, 20'h00039, 20'h0003A, 20'h00041, 20'h00047, 20'h0004A, 20'h0004B,
    20'h0004C, 20'h0004D, 20'h0004E, 20'h0004F, 20'h0004F, 20'h00051, 20'h00052, 20'h00056,
    20'h00058, 20'h00059, 20'h0005A, 20'h0005D, 20'h0005E, 20'h00072, 20'h00073, 20'h002FC};

  // Value when the option condition does not apply (also the asynchronous reset value)
  localparam logic [7:0] REG_RST [REG_N] = '{
    8'h00, 8'h00, 8'h28, 8'h20, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3F, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00,
    8'h07, 8'hC2, 8'h8A, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Value when the option bit reads 0
  localparam logic [7:0] REG_ALT [REG_N] = '{
    8'h00, 8'h00, 8'h28, 8'h20, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3F, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h20,
    8'h07, 8'hC3, 8'h8A, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [7:0] REG_WMASK [REG_N] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  localparam logic [2:0] REG_OPT [REG_N] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2,
    3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3,
    3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

  // ==========================================================================
  // Region decoder; the vector table is tested before the ROM that contains it
  function automatic masb_region_t masb_decode(input logic [19:0] a);
    masb_region_t r;
    r = REGION_NONE;
    if (a >= VEC_LO && a <= VEC_HI) begin
      r = REGION_VECTOR;
    end else if (a >= ROM_LO && a <= ROM_HI) begin
      r = REGION_ROM;
    end else if (a >= FLASH_LO && a <= FLASH_HI) begin
      r = REGION_FLASH;
    end else if (a >= RAM_LO && a <= RAM_HI) begin
      r = REGION_RAM;
    end else if (a <= SFR0_HI) begin
      r = REGION_SFR_LOW;
    end else if (a >= SFR1_LO && a <= SFR1_HI) begin
      r = REGION_SFR_HIGH;
    end
    return r;
  endfunction

endpackage

// >>> masb_byte_reg.sv
/*
  One byte-wide peripheral register with a write mask and a synchronous reload.
  Assumes the reload value is held stable while i_load is high.
*/
`timescale 1ns/1ps
module masb_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK   = 8'hFF
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // Reload and write
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_val,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  // Value
  output logic      [7:0] o_q
);

  // ==========================================================================
  // Storage; reload wins over a write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= RST_VAL;
    end else if (i_load) begin
      o_q <= i_load_val;
    end else if (i_we) begin
      o_q <= (o_q & ~WMASK) | (i_wdata & WMASK);
    end
  end

endmodule

// >>> masb_sfr_bank.sv
/*
  Address map decoder and peripheral register bank behind an Avalon-MM slave.
  Assumes word addressing: slave word index equals the CPU byte address; data in bits 7:0.
  Secondary reset requests and option bits are synchronous to i_clk_sys.
*/
// Function
// - Decode a full 20-bit one-megabyte space
// - Program ROM at 08000h through 0FFFFh
// - Vector table at 0FFDCh through 0FFFFh
// - Data flash at 03000h through 03FFFh
// - RAM from 00400h to 00DFFh, data and stack
// - Register windows 00000h-002FFh and 02C00h-02FFFh
// - Empty addresses in register windows are reserved
// - Cold/warm bit cleared on power-on, monitor-0 reset
// - Cold/warm bit kept on pin, software, watchdog
// - Count-source protect reset follows protect option
// - Second voltage-detect reset follows start option
// - Monitor-0 control reset follows start option
// - 004Fh steered by serial/two-wire select bit
// - Peripheral interrupt controls reset low three bits
// - Pin interrupt controls clear bits 5:4, 2:0
// - Transfer vector area 2C00h-2C3Fh, undefined contents
`timescale 1ns/1ps
module masb_sfr_bank
  import masb_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  // Secondary reset requests
  input  wire logic                  i_rst_pin,
  input  wire logic                  i_rst_soft,
  input  wire logic                  i_rst_wdog,
  input  wire logic                  i_rst_vmon0,
  // Option area bits
  input  wire logic                  i_opt_protect_init,
  input  wire logic                  i_opt_vdetect_start,
  // Avalon-MM slave
  input  wire logic [BUS_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [RDATA_W-1:0]    i_avs_writedata,
  input  wire logic [BE_W-1:0]       i_avs_byteenable,
  output logic      [RDATA_W-1:0]    o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Status
  output masb_region_t               o_region,
  output logic                       o_reserved_hit,
  output logic                       o_wdog_refresh,
  output logic                       o_wdog_start,
  output logic                       o_twowire_sel
);

  // ==========================================================================
  // Bus handshake: one wait state on every access
  logic                  ack_q;
  logic                  req;
  logic                  wr_acc;
  logic [BYTE_W-1:0]     wbyte;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_acc            = i_avs_write & ack_q & i_avs_byteenable[0];
  assign wbyte             = i_avs_writedata[BYTE_W-1:0];

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ==========================================================================
  // Reset sequencing
  // Option bits cannot feed an asynchronous reset, so defaults are reloaded one cycle after release
  logic init_q;
  logic any_soft_rst;

  assign any_soft_rst = i_rst_pin | i_rst_soft | i_rst_wdog | i_rst_vmon0;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      init_q <= 1'b1;
    end else begin
      init_q <= any_soft_rst;
    end
  end

  // ==========================================================================
  // Address decode
  masb_region_t          region;
  logic [REG_N-1:0]      reg_hit;
  logic                  rstcause_hit;
  logic                  wdr_hit;
  logic                  wds_hit;
  logic                  xfer_hit;
  logic [XFER_IDX_W-1:0] xfer_idx;
  logic                  in_sfr;
  logic                  reserved;
  logic [19:0]           xfer_off;

  assign region       = masb_decode(i_avs_address);
  assign in_sfr       = (region == REGION_SFR_LOW) || (region == REGION_SFR_HIGH);
  assign rstcause_hit = (i_avs_address == RSTCAUSE_OFS);
  assign wdr_hit      = (i_avs_address == WDOG_RFSH_OFS);
  assign wds_hit      = (i_avs_address == WDOG_STRT_OFS);
  assign xfer_hit     = (i_avs_address >= XFER_LO) && (i_avs_address <= XFER_HI);
  assign xfer_off     = i_avs_address - XFER_LO;
  assign xfer_idx     = xfer_off[XFER_IDX_W-1:0];
  // Everything in a window that no register or store claims
  assign reserved     = in_sfr & ~(|reg_hit) & ~rstcause_hit & ~wdr_hit & ~wds_hit
                      & ~xfer_hit;

  // ==========================================================================
  // Register array
  logic [REG_N-1:0][BYTE_W-1:0] reg_val;

  assign o_twowire_sel = reg_val[IDX_SER_SEL][TWOWIRE_SEL_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < REG_N; gi++) begin : g_reg
      logic [BYTE_W-1:0] load_val;
      logic              sel_ok;

      always_comb begin
        case (REG_OPT[gi])
          OPT_SYNSER:  sel_ok = ~o_twowire_sel;
          OPT_TWOWIRE: sel_ok = o_twowire_sel;
          default:     sel_ok = 1'b1;
        endcase
      end

      always_comb begin
        case (REG_OPT[gi])
          OPT_PROTECT: load_val = i_opt_protect_init ? REG_RST[gi] : REG_ALT[gi];
          OPT_VDETECT: load_val = i_opt_vdetect_start ? REG_RST[gi] : REG_ALT[gi];
          default:     load_val = REG_RST[gi];
        endcase
      end

      assign reg_hit[gi] = (i_avs_address == REG_OFS[gi]) & sel_ok;

      masb_byte_reg #(
        .RST_VAL (REG_RST[gi]),
        .WMASK   (REG_WMASK[gi])
      ) u_reg (
        .i_clk_sys  (i_clk_sys),
        .i_resetn   (i_resetn),
        .i_load     (init_q),
        .i_load_val (load_val),
        .i_we       (wr_acc & reg_hit[gi]),
        .i_wdata    (wbyte),
        .o_q        (reg_val[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Reset cause: only the cold/warm bit is held; software writes 1 to mark a warm start
  logic cold_warm_q;

  // Pin, software and watchdog resets are deliberately absent, so the bit survives them
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cold_warm_q <= 1'b0;
    end else if (i_rst_vmon0) begin
      cold_warm_q <= 1'b0;
    end else if (wr_acc & rstcause_hit & wbyte[COLD_WARM_BIT]) begin
      cold_warm_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Transfer-controller storage: no reset, contents undefined until written
  logic [BYTE_W-1:0] xfer_mem_q [XFER_BYTES];

  always_ff @(posedge i_clk_sys) begin
    if (wr_acc & xfer_hit) begin
      xfer_mem_q[xfer_idx] <= wbyte;
    end
  end

  // ==========================================================================
  // Read mux; memories live outside this block, so their regions read zero here
  logic [BYTE_W-1:0] rd_byte;

  always_comb begin
    rd_byte = ZERO_BYTE;
    for (int k = 0; k < REG_N; k++) begin
      if (reg_hit[k]) begin
        rd_byte = rd_byte | reg_val[k];
      end
    end
    if (rstcause_hit) begin
      rd_byte[COLD_WARM_BIT] = cold_warm_q;
    end
    if (xfer_hit) begin
      rd_byte = xfer_mem_q[xfer_idx];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= {{(RDATA_W-BYTE_W){1'b0}}, rd_byte};
    end
  end

  // ==========================================================================
  // Status outputs, captured on the accepting edge
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_region       <= REGION_NONE;
      o_reserved_hit <= 1'b0;
    end else begin
      if (req & ack_q) begin
        o_region <= region;
      end
      o_reserved_hit <= req & ack_q & reserved;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wdog_refresh <= 1'b0;
      o_wdog_start   <= 1'b0;
    end else begin
      o_wdog_refresh <= wr_acc & wdr_hit;
      o_wdog_start   <= wr_acc & wds_hit;
    end
  end

  // ==========================================================================
  // Checks
  // Bounds come from the package so a moved region cannot hide behind a stale number
  sequence s_reload;
    init_q ##1 1'b1;
  endsequence

  sequence s_rd_issue;
    i_avs_read && !ack_q;
  endsequence

  sequence s_accept;
    req && ack_q;
  endsequence

  a_coldwarm_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_rst_vmon0
    |=> !cold_warm_q)
    else $error("cold/warm bit not cleared");

  a_coldwarm_keep: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (i_rst_pin || i_rst_soft || i_rst_wdog) && !i_rst_vmon0 && !(wr_acc && rstcause_hit)
    |=> $stable(cold_warm_q))
    else $error("cold/warm bit changed on warm reset");

  a_protect_reload: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_reload
    |-> reg_val[IDX_CSRC_PROT] == ($past(i_opt_protect_init) ? 8'h00 : 8'h80))
    else $error("protect reset wrong");

  a_vdet2_reload: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    init_q
    |=> reg_val[IDX_VDET2] == ($past(i_opt_vdetect_start) ? 8'h00 : 8'h20))
    else $error("detect2 reset wrong");

  a_vmon0_reload: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    init_q
    |=> reg_val[IDX_VMON0] == ($past(i_opt_vdetect_start) ? 8'hC2 : 8'hC3))
    else $error("monitor0 reset wrong");

  a_irqc_low_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    init_q
    |=> reg_val[IDX_TMRC_IRQ][2:0] == 3'h0)
    else $error("interrupt control low bits not cleared");

  a_pin_irqc_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    init_q
    |=> reg_val[IDX_PIN0_IRQ][5:4] == 2'h0 && reg_val[IDX_PIN0_IRQ][2:0] == 3'h0)
    else $error("pin control reset");

  a_sel_twowire: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_rd_issue ##0 (i_avs_address == REG_OFS[IDX_TWI_IRQ]) && !init_q
    |=> o_avs_readdata[7:0] == (o_twowire_sel ? reg_val[IDX_TWI_IRQ] : reg_val[IDX_SSER_IRQ]))
    else $error("004F steer");

  a_reserved_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    wr_acc && reserved && !init_q && !i_rst_vmon0
    |=> $stable(reg_val) && $stable(cold_warm_q))
    else $error("reserved write changed state");

  a_reserved_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_rd_issue ##0 reserved
    |=> o_avs_readdata == 32'h0)
    else $error("reserved read not zero");

  a_bus_answer: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    req && !ack_q
    |=> !o_avs_waitrequest || !req)
    else $error("no answer after one wait state");

  a_region_rom: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address >= ROM_LO && i_avs_address <= ROM_HI
    |=> o_region == (($past(i_avs_address) >= VEC_LO) ? REGION_VECTOR : REGION_ROM))
    else $error("rom decode");

  a_region_ram: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address >= RAM_LO && i_avs_address <= RAM_HI
    |=> o_region == REGION_RAM)
    else $error("ram decode");

  a_region_flash: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address >= FLASH_LO && i_avs_address <= FLASH_HI
    |=> o_region == REGION_FLASH)
    else $error("flash decode");

  a_region_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address <= SFR0_HI
    |=> o_region == REGION_SFR_LOW)
    else $error("low window decode");

  a_region_high: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address >= SFR1_LO && i_avs_address <= SFR1_HI
    |=> o_region == REGION_SFR_HIGH)
    else $error("high window decode");

  a_region_none: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_accept ##0 i_avs_address > VEC_HI
    |=> o_region == REGION_NONE)
    else $error("unallocated decode");

  a_wdog_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    wr_acc && (wdr_hit || wds_hit)
    |=> o_wdog_refresh == $past(wdr_hit) && o_wdog_start == $past(wds_hit))
    else $error("watchdog pulse wrong");

endmodule

// >>> masb_rst_ctrl.sv
/*
  Partner model: the reset controller that turns one request into one secondary reset pulse.
  Assumes requests arrive by non-blocking assignment right after a rising clock edge.
*/
`timescale 1ns/1ps
module masb_rst_ctrl (
  // Clock and power-on reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // Request
  input  wire logic       i_fire,
  input  wire logic [1:0] i_kind,
  // Reset pulses
  output logic            o_rst_pin,
  output logic            o_rst_soft,
  output logic            o_rst_wdog,
  output logic            o_rst_vmon0
);
  // ==========================================================================
  // Pulse generation
  // One source at a time, one cycle long, so the bank never sees two causes at once
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rst_pin   <= 1'b0;
      o_rst_soft  <= 1'b0;
      o_rst_wdog  <= 1'b0;
      o_rst_vmon0 <= 1'b0;
    end else begin
      o_rst_pin   <= i_fire && (i_kind == 2'h0);
      o_rst_soft  <= i_fire && (i_kind == 2'h1);
      o_rst_wdog  <= i_fire && (i_kind == 2'h2);
      o_rst_vmon0 <= i_fire && (i_kind == 2'h3);
    end
  end
endmodule

// >>> masb_sfr_bank_tb.sv
/*
  Self-checking bench for the address map and register bank: Avalon-MM master tasks and test sequences.
  Assumes a slave with one wait state per access and the reset controller partner model.
*/
`timescale 1ns/1ps
module masb_sfr_bank_tb;
  import masb_pkg::*;
  logic         i_clk_sys;
  logic         i_resetn;
  logic         rst_pin, rst_soft, rst_wdog, rst_vmon0;
  logic         fire;
  logic [1:0]   kind;
  logic         opt_prot, opt_vdet;
  logic [19:0]  addr;
  logic         rd, wr;
  logic [31:0]  wdata, rdata, last_rdata;
  logic [3:0]   be;
  logic         waitreq, res_hit, rfsh, strt, tw_sel;
  masb_region_t region, seen_reg;
  logic         seen_res, seen_rfsh, seen_strt;
  int           error_cnt, check_count, cyc;

  localparam logic [19:0] RV_A [12] = '{20'h00004, 20'h00006, 20'h00007, 20'h0000C, 20'h0000F, 20'h00033,
    20'h00036, 20'h00039, 20'h0003A, 20'h00041, 20'h00059, 20'h0004F};
  localparam logic [7:0] RV_D [12] = '{8'h00, 8'h28, 8'h20, 8'h04, 8'h3F, 8'h08, 8'h07, 8'h8A, 8'h82,
    8'h00, 8'h00, 8'h00};
  localparam logic [19:0] RG_A [20] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF, 20'h00400, 20'h00DFF,
    20'h00E00, 20'h02BFF, 20'h02C00, 20'h02FFF, 20'h03000, 20'h03FFF, 20'h04000, 20'h07FFF, 20'h08000,
    20'h0FFDB, 20'h0FFDC, 20'h0FFFF, 20'h10000, 20'hFFFFF};
  localparam masb_region_t RG_E [20] = '{REGION_SFR_LOW, REGION_SFR_LOW, REGION_NONE, REGION_NONE,
    REGION_RAM, REGION_RAM, REGION_NONE, REGION_NONE, REGION_SFR_HIGH, REGION_SFR_HIGH, REGION_FLASH,
    REGION_FLASH, REGION_NONE, REGION_NONE, REGION_ROM, REGION_ROM, REGION_VECTOR, REGION_VECTOR,
    REGION_NONE, REGION_NONE};
  localparam logic [19:0] DT_A [6] = '{20'h02C00, 20'h02C3F, 20'h02C40, 20'h02C47, 20'h02C48, 20'h02C6F};

  masb_sfr_bank uut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_rst_pin(rst_pin), .i_rst_soft(rst_soft),
    .i_rst_wdog(rst_wdog), .i_rst_vmon0(rst_vmon0), .i_opt_protect_init(opt_prot),
    .i_opt_vdetect_start(opt_vdet), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_region(region), .o_reserved_hit(res_hit), .o_wdog_refresh(rfsh), .o_wdog_start(strt),
    .o_twowire_sel(tw_sel));

  masb_rst_ctrl partner (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_fire(fire), .i_kind(kind), .o_rst_pin(rst_pin),
    .o_rst_soft(rst_soft), .o_rst_wdog(rst_wdog), .o_rst_vmon0(rst_vmon0));

  // ==========================================================================
  // Clock and hang guard
  always #4 i_clk_sys = ~i_clk_sys;

  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Called just after a rising edge; holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [19:0] a, input logic [7:0] d, input logic [3:0] b);
    addr  <= a;
    wdata <= {24'h000000, d};
    be    <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    @(posedge i_clk_sys);
    while (waitreq !== 1'b0) @(posedge i_clk_sys);
    last_rdata = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk_sys);
    seen_res  = res_hit;
    seen_reg  = region;
    seen_rfsh = rfsh;
    seen_strt = strt;
  endtask

  task automatic wr8(input logic [19:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input string name, input logic [19:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(name, last_rdata, {24'h000000, exp});
  endtask

  task automatic por(input logic p, input logic v);
    opt_prot <= p;
    opt_vdet <= v;
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask

  task automatic sec(input logic [1:0] k);
    kind <= k;
    fire <= 1'b1;
    @(posedge i_clk_sys);
    fire <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask

  // ==========================================================================
  // Tests
  initial begin
    i_clk_sys = 1'b0;
    {i_resetn, fire, kind, opt_prot, opt_vdet, rd, wr} = '0;
    {addr, wdata, be, cyc, error_cnt, check_count} = '0;
    // Both option settings, each with a fresh power-on reset
    for (int o = 0; o < 2; o++) begin
      por(o[0], o[0]);
      for (int i = 0; i < 12; i++) rdc("reset value", RV_A[i], RV_D[i]);
      rdc("count source protect", 20'h0001C, o ? 8'h00 : 8'h80);
      rdc("voltage detect 2", 20'h00034, o ? 8'h00 : 8'h20);
      rdc("monitor 0 control", 20'h00038, o ? 8'hC2 : 8'hC3);
      rdc("cold warm after power-on", 20'h0000B, 8'h00);
      wr8(20'h0000B, 8'h80);
    end
    $display("test reset_values done");
    wr8(20'h00004, 8'hFF);
    rdc("rw register", 20'h00004, 8'hFF);
    bus(1'b1, 20'h00004, 8'h12, 4'h0);
    rdc("byte lane off", 20'h00004, 8'hFF);
    wr8(20'h00033, 8'hFF);
    rdc("read-only register", 20'h00033, 8'h08);
    wr8(20'h00041, 8'hFF);
    rdc("irq control rw", 20'h00041, 8'hFF);
    $display("test access_kinds done");
    bus(1'b0, 20'h00000, 8'h00, 4'h1);
    chk("reserved hit read", seen_res, 1'b1);
    wr8(20'h00010, 8'h55);
    chk("reserved hit write", seen_res, 1'b1);
    rdc("reserved read", 20'h00010, 8'h00);
    rdc("no side effect", 20'h00004, 8'hFF);
    $display("test reserved done");
    for (int i = 0; i < 6; i++) wr8(DT_A[i], DT_A[i][7:0] ^ 8'h5A);
    for (int i = 0; i < 6; i++) rdc("transfer area", DT_A[i], DT_A[i][7:0] ^ 8'h5A);
    bus(1'b0, 20'h02C40, 8'h00, 4'h1);
    chk("transfer area not reserved", seen_res, 1'b0);
    $display("test transfer_area done");
    for (int i = 0; i < 20; i++) begin
      bus(1'b0, RG_A[i], 8'h00, 4'h1);
      chk("region", {29'h0, seen_reg}, {29'h0, RG_E[i]});
      if (i != 8) chk("region read data", last_rdata, 32'h00000000);
    end
    $display("test regions done");
    opt_prot <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr8(20'h0000B, 8'h80);
      wr8(20'h00004, 8'h5A);
      sec(k[1:0]);
      rdc("cold warm bit", 20'h0000B, (k == 3) ? 8'h00 : 8'h80);
      rdc("reload on reset", 20'h00004, 8'h00);
    end
    rdc("protect option resampled", 20'h0001C, 8'h80);
    $display("test reset_sources done");
    wr8(20'h0000D, 8'h00);
    chk("refresh pulse", {seen_rfsh, seen_strt}, 2'h2);
    wr8(20'h0000E, 8'h00);
    chk("start pulse", {seen_rfsh, seen_strt}, 2'h1);
    rdc("write-only read", 20'h0000D, 8'h00);
    $display("test watchdog done");
    wr8(20'h0004F, 8'h05);
    wr8(20'h002FC, 8'h01);
    chk("two-wire select", tw_sel, 1'b1);
    rdc("two-wire irq control", 20'h0004F, 8'h00);
    wr8(20'h0004F, 8'h06);
    rdc("two-wire irq written", 20'h0004F, 8'h06);
    wr8(20'h002FC, 8'h00);
    chk("serial select", tw_sel, 1'b0);
    rdc("serial irq control", 20'h0004F, 8'h05);
    $display("test shared_address done");
    report_and_stop();
  end
endmodule
